// >>> verif/tmc_pin_model.sv
`timescale 1ns/1ps

module tmc_pin_model
  import tmc_pkg::*;
(
  // clock
  input  wire logic pclk,
  // pins toward the block
  output tmc_pins_t pins
);
  // all pins idle high
  initial pins = 4'hf;

  // n falling edges on count pin 0, each level held 30 cycles
  task automatic pulses(input int n);
    repeat (n)
    begin
      repeat (30) @(posedge pclk);
      pins.cnt0 <= 1'b0;
      repeat (30) @(posedge pclk);
      pins.cnt0 <= 1'b1;
    end
  endtask

  // interrupt pin 0 level, changed after a rising edge
  task automatic set_irq0(input logic v);
    @(posedge pclk);
    pins.irq0 <= v;
  endtask
endmodule // tmc_pin_model

// >>> verif/tmc_timers_tb.sv
`timescale 1ns/1ps

module tmc_timers_tb
  import tmc_pkg::*;
();
  // bench signals
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        ce      = 1'b1;
  logic [3:0]  pstrb   = 4'hf;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  tmc_pins_t   pins;
  tmc_ack_t    ack     = 4'h0;
  logic        ovf0, ovf1, eflag0, eflag1, cko, cko_oe;
  logic [31:0] rd;
  logic        serr;
  int          err_total  = 0;
  int          num_checks = 0;
  int          cyc        = 0;

  // clock at 40 MHz
  always #12.5 pclk = ~pclk;

  tmc_pin_model pm (.pclk(pclk), .pins(pins));

  tmc_timers #(.ADDR_W(12)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .ack(ack),
    .timer0_overflow_flag(ovf0), .timer1_overflow_flag(ovf1),
    .ext_irq0_flag(eflag0), .ext_irq1_flag(eflag1),
    .timer0_clock_out(cko), .timer0_clock_out_oe(cko_oe)
  );

  // verdict and end of run
  task automatic report_and_stop();
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  // compare and report
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    serr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, rd, exp);
  endtask

  // one output chosen by number
  function automatic logic pick(input int s);
    return s == 0 ? ovf0 : (s == 1 ? ovf1 : eflag0);
  endfunction

  // edges until the output equals v, at most 100
  task automatic wait_hi(input int s, input logic v, output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pick(s) !== v && n < 100);
  endtask

  // cycles between two timer 0 overflows, flag cleared by vectoring
  task automatic period(input string what, input int exp);
    int   n;
    logic c;
    wait_hi(0, 1'b1, n);
    c = cko;
    ack.tim0 <= 1'b1;
    @(posedge pclk);
    ack.tim0 <= 1'b0;
    wait_hi(0, 1'b1, n);
    chk(what, n + 1, exp);
    chk("clock out", cko ^ c, 32'h1);
  endtask

  task automatic t_reset();
    int n;
    chk("flags", {ovf1, ovf0, eflag1, eflag0}, 32'h0);
    chk("clock out", {cko, cko_oe}, 32'h2);
    rdchk("ctrl", TMC_IDX_CTRL, TMC_CTRL_RST);
    rdchk("mode", TMC_IDX_MODE, TMC_MODE_RST);
    rdchk("tl0", TMC_IDX_TL0, TMC_CNT_RST);
    rdchk("th0", TMC_IDX_TH0, TMC_CNT_RST);
    apb(1'b0, 8'h90, 8'h00);
    chk("unmapped", {serr, rd[7:0]}, 32'h100);
  endtask

  task automatic t_regs();
    logic [7:0] idx [6] = '{TMC_IDX_MODE, TMC_IDX_TL0, TMC_IDX_TH0,
                            TMC_IDX_TL1, TMC_IDX_TH1, TMC_IDX_AUX2};
    logic [7:0] val [6] = '{8'ha5, 8'h3c, 8'hc3, 8'h5a, 8'h96, 8'hff};
    foreach (idx[i])
    begin
      wr(idx[i], val[i]);
      rdchk("reg", idx[i], val[i] & (idx[i] == TMC_IDX_AUX2 ? TMC_AUX_MASK : 8'hff));
    end
    @(negedge pclk);
    chk("oe", cko_oe, 32'h1);
    wr(TMC_IDX_AUX2, 8'h00);
    wr(TMC_IDX_MODE, 8'h00);
  endtask

  task automatic t_flags();
    int n;
    wr(TMC_IDX_CTRL, 8'ha0);
    @(negedge pclk);
    chk("sw set", {ovf1, ovf0}, 32'h3);
    @(posedge pclk);
    ack <= 4'h5;
    @(posedge pclk);
    ack <= 4'h0;
    @(negedge pclk);
    chk("ack clear", {ovf1, ovf0}, 32'h0);
    // gate closed while interrupt pin low, level flag follows pin
    wr(TMC_IDX_MODE, 8'h09);
    wr(TMC_IDX_TL0, 8'h00);
    pm.set_irq0(1'b0);
    wr(TMC_IDX_CTRL, 8'h10);
    repeat (60) @(posedge pclk);
    chk("level flag", eflag0, 32'h1);
    rdchk("gated", TMC_IDX_TL0, 32'h0);
    pm.set_irq0(1'b1);
    repeat (60) @(posedge pclk);
    chk("level flag", eflag0, 32'h0);
    apb(1'b0, TMC_IDX_TL0, 8'h00);
    chk("gate open", rd != 0, 32'h1);
    // falling edge sets, vectoring clears while pin stays low
    wr(TMC_IDX_CTRL, 8'h01);
    pm.set_irq0(1'b0);
    wait_hi(2, 1'b1, n);
    chk("edge flag", n < 10, 32'h1);
    @(posedge pclk);
    ack <= 4'h2;
    @(posedge pclk);
    ack <= 4'h0;
    @(negedge pclk);
    chk("edge clear", eflag0, 32'h0);
    pm.set_irq0(1'b1);
  endtask

  task automatic t_period();
    wr(TMC_IDX_MODE, 8'h02);
    wr(TMC_IDX_TH0, 8'hfe);
    wr(TMC_IDX_TL0, 8'hfe);
    wr(TMC_IDX_AUX2, 8'h01);
    wr(TMC_IDX_CTRL, 8'h10);
    period("slow period", 2 * TMC_PRESCALE);
    rdchk("reload src", TMC_IDX_TH0, 32'hfe);
    wr(TMC_IDX_TH0, 8'hf8);
    wr(TMC_IDX_AUX2, 8'h81);
    wr(TMC_IDX_CTRL, 8'h10);
    period("fast period", 8);
    // reload all ones overflows every cycle; a vectoring clear must lose
    wr(TMC_IDX_TH0, 8'hff);
    repeat (9) @(posedge pclk);
    ack.tim0 <= 1'b1;
    @(posedge pclk);
    ack.tim0 <= 1'b0;
    @(negedge pclk);
    chk("set beats clear", ovf0, 32'h1);
  endtask

  task automatic t_wrap();
    int         n;
    logic [7:0] md [3] = '{8'h00, 8'h01, 8'h01};
    logic [7:0] tl [3] = '{8'h1f, 8'h1f, 8'hff};
    logic       e  [3] = '{1'b1, 1'b0, 1'b1};
    foreach (md[i])
    begin
      wr(TMC_IDX_CTRL, 8'h00);
      wr(TMC_IDX_MODE, md[i]);
      wr(TMC_IDX_TH0, 8'hff);
      wr(TMC_IDX_TL0, tl[i]);
      wr(TMC_IDX_CTRL, 8'h10);
      wait_hi(0, 1'b1, n);
      wr(TMC_IDX_CTRL, 8'h00);
      chk("wrap", n < 100, e[i]);
      rdchk("th0 after", TMC_IDX_TH0, e[i] ? 32'h00 : 32'hff);
    end
  endtask

  task automatic t_count();
    wr(TMC_IDX_MODE, 8'h05);
    wr(TMC_IDX_TL0, 8'h00);
    wr(TMC_IDX_CTRL, 8'h10);
    pm.pulses(5);
    repeat (40) @(posedge pclk);
    rdchk("events", TMC_IDX_TL0, 32'h05);
  endtask

  // clock enable low freezes counting; a write without byte lane 0 is dropped
  task automatic t_hold();
    wr(TMC_IDX_CTRL, 8'h00);
    wr(TMC_IDX_MODE, 8'h01);
    wr(TMC_IDX_TL0, 8'h10);
    ce <= 1'b0;
    wr(TMC_IDX_CTRL, 8'h10);
    repeat (30) @(posedge pclk);
    rdchk("frozen", TMC_IDX_TL0, 32'h10);
    ce <= 1'b1;
    apb(1'b0, TMC_IDX_TL0, 8'h00);
    chk("resumed", rd != 32'h10, 32'h1);
    pstrb <= 4'he;
    wr(TMC_IDX_MODE, 8'h77);
    pstrb <= 4'hf;
    rdchk("strobe", TMC_IDX_MODE, 32'h01);
  endtask

  task automatic t_split();
    int n;
    wr(TMC_IDX_CTRL, 8'h00);
    wr(TMC_IDX_MODE, 8'h33);
    wr(TMC_IDX_TL1, 8'h55);
    wr(TMC_IDX_TH0, 8'hff);
    wr(TMC_IDX_TL0, 8'hff);
    wr(TMC_IDX_CTRL, 8'h40);
    wait_hi(1, 1'b1, n);
    chk("high ovf", n < 100, 32'h1);
    chk("low idle", ovf0, 32'h0);
    rdchk("t1 held", TMC_IDX_TL1, 32'h55);
    wr(TMC_IDX_CTRL, 8'h10);
    wait_hi(0, 1'b1, n);
    chk("low ovf", n < 100, 32'h1);
    chk("no t1 flag", ovf1, 32'h0);
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2)
    begin
      @(negedge pclk);
      chk("reset flags", {ovf1, ovf0, eflag1, eflag0}, 32'h0);
    end
    repeat (2) @(posedge pclk);
    t_reset();
    t_regs();
    t_flags();
    t_period();
    t_wrap();
    t_count();
    t_hold();
    t_split();
    report_and_stop();
  end
endmodule // tmc_timers_tb

// >>> verilog/tmc_pkg.sv
package tmc_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0] TMC_IDX_AUX2 = 8'h87;
  localparam logic [7:0] TMC_IDX_CTRL = 8'h88;
  localparam logic [7:0] TMC_IDX_MODE = 8'h89;
  localparam logic [7:0] TMC_IDX_TL0  = 8'h8a;
  localparam logic [7:0] TMC_IDX_TL1  = 8'h8b;
  localparam logic [7:0] TMC_IDX_TH0  = 8'h8c;
  localparam logic [7:0] TMC_IDX_TH1  = 8'h8d;

  // timer_control_status field positions
  localparam int unsigned TMC_CTRL_TF1 = 7;
  localparam int unsigned TMC_CTRL_TR1 = 6;
  localparam int unsigned TMC_CTRL_TF0 = 5;
  localparam int unsigned TMC_CTRL_TR0 = 4;
  localparam int unsigned TMC_CTRL_IE1 = 3;
  localparam int unsigned TMC_CTRL_IT1 = 2;
  localparam int unsigned TMC_CTRL_IE0 = 1;
  localparam int unsigned TMC_CTRL_IT0 = 0;

  // timer_mode_select nibble layout (timer 1 high nibble, timer 0 low)
  localparam int unsigned TMC_NIB_W    = 4;
  localparam int unsigned TMC_NIB_GATE = 3;
  localparam int unsigned TMC_NIB_SRC  = 2;
  localparam int unsigned TMC_NIB_MODE = 0;

  // auxiliary_control_two field positions
  localparam int unsigned TMC_AUX_FAST0 = 7;
  localparam int unsigned TMC_AUX_FAST1 = 6;
  localparam int unsigned TMC_AUX_CKOE0 = 0;
  localparam logic [7:0]  TMC_AUX_MASK  = 8'hc1;

  // values after reset
  localparam logic [7:0] TMC_CTRL_RST = 8'h00;
  localparam logic [7:0] TMC_MODE_RST = 8'h00;
  localparam logic [7:0] TMC_CNT_RST  = 8'h00;
  localparam logic [7:0] TMC_AUX_RST  = 8'h00;

  // prescaler: cycles of pclk per timer rate cycle
  localparam int unsigned TMC_PRESCALE = 12;
  localparam logic [3:0]  TMC_PRE_LAST = 4'(TMC_PRESCALE - 1);

  // operating modes
  typedef enum logic [1:0] {
    TMC_M13   = 2'b00,
    TMC_M16   = 2'b01,
    TMC_M8RLD = 2'b10,
    TMC_MSPLT = 2'b11
  } tmc_mode_t;

  // external pins, grouped
  typedef struct packed {
    logic irq1;
    logic irq0;
    logic cnt1;
    logic cnt0;
  } tmc_pins_t;

  // vectoring acknowledges from the interrupt controller
  typedef struct packed {
    logic ext1;
    logic tim1;
    logic ext0;
    logic tim0;
  } tmc_ack_t;

endpackage

// >>> verilog/tmc_sync.sv
`timescale 1ns/1ps

module tmc_sync
  import tmc_pkg::*;
#(
  parameter int unsigned W = 4
)(
  // clock, reset, clock enable
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  // two stages; the first is read only by the second
  always_comb
  begin
    meta_d = ce ? d : meta_q;
    q_d    = ce ? meta_q : q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '1; // pins idle high, so no false edge follows reset
      q      <= '1;
    end
    else
    begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end

endmodule // tmc_sync

// >>> verilog/tmc_timers.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps

// Operation
// R01: in timer function each timer advances once every twelve clock cycles
// R02: fast clock select makes that timer advance on every clock cycle
// R03: count pin sampled each rate cycle; high then low sample counts one
// R04: counted edge becomes visible at the end of the next rate cycle
// R05: mode 0 is a 13-bit counter; wrap from all ones sets overflow flag
// R06: counting only with run set and gating off or interrupt pin high
// R07: mode 1 is mode 0 using the full 16-bit count
// R08: mode 2 low byte counts; overflow sets flag, reloads low from high
// R09: timer 1 in mode 3 stops and holds its count
// R10: timer 0 mode 3 low byte is an 8-bit counter with timer 0 controls
// R11: timer 0 mode 3 high byte counts clock, runs on timer 1 run bit, flag
// R12: mode codes: 13-bit, 16-bit, 8-bit reload, split or stopped
// R13: mode register: timer 1 high nibble, timer 0 low; gate, source, mode
// R14: source bit 0 selects internal clock, 1 selects the count pin
// R15: overflow flags set by overflow, cleared by vectoring, software writable
// R16: run bits start and stop their timers
// R17: external flags set on edge or level; vectoring clears edge flags only
// R18: trigger type 0 is low level, 1 is falling edge
// R19: timer 0 fast select at aux bit 7 picks undivided clock
// R20: timer 0 clock output enable at aux bit 0 drives a toggling clock out
// R21: writing a count byte loads it at once; reads return the live count
module tmc_timers
  import tmc_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
)(
  // clock, reset, clock enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // external pins and vectoring acknowledges
  input  wire tmc_pins_t         pins,
  input  wire tmc_ack_t          ack,
  // interrupt request flags and clock out
  output logic                   timer0_overflow_flag,
  output logic                   timer1_overflow_flag,
  output logic                   ext_irq0_flag,
  output logic                   ext_irq1_flag,
  output logic                   timer0_clock_out,
  output logic                   timer0_clock_out_oe
);

  // one timer step for modes 0..2, mode 3 holds; timer 0 mode 3 is handled by the caller
  function automatic logic [16:0] tmc_step(logic [7:0] hi, logic [7:0] lo,
                                           tmc_mode_t m, logic inc);
    logic [5:0]  s5;
    logic [16:0] s16;
    logic [16:0] r;
    s5  = {1'b0, lo[4:0]} + 6'(inc);
    s16 = {1'b0, hi, lo} + 17'(inc);
    r   = {1'b0, hi, lo};
    unique case (m) // see R12
      TMC_M13:   r = {s5[5] & (hi == 8'hff), hi + 8'(s5[5]), lo[7:5], s5[4:0]}; // see R05
      TMC_M16:   r = s16; // see R07
      TMC_M8RLD: r = (inc && lo == 8'hff) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'(inc)}; // see R08
      TMC_MSPLT: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  // synchronised pins
  tmc_pins_t   pins_s;
  logic        cnt_s [2];
  logic        irq_s [2];

  // register state
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  mode_q, mode_d;
  logic [7:0]  aux_q, aux_d;
  logic [7:0]  tl0_q, tl0_d, th0_q, th0_d;
  logic [7:0]  tl1_q, tl1_d, th1_q, th1_d;
  logic        clko_q, clko_d;
  logic [3:0]  pre_q, pre_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;

  // per timer datapath
  logic        tick12;
  logic        fast [2];
  logic        tr [2];
  logic        rate [2];
  logic        run_en [2];
  logic        inc [2];
  logic        samp_q [2];
  logic        samp_d [2];
  logic        pend_q [2];
  logic        pend_d [2];
  logic        irqp_q [2];
  logic        irqp_d [2];
  logic        irq_fall [2];

  // bus decode
  logic [7:0]  idx;
  logic        hit;
  logic        wr_en;
  logic        wr_ctrl, wr_mode, wr_aux, wr_tl0, wr_th0, wr_tl1, wr_th1;

  // step results
  tmc_mode_t   m0, m1;
  logic [16:0] st0, st1;
  logic        th0_inc;
  logic        tf0_set, tf1_set, ie0_set, ie1_set;

  tmc_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (pins),
    .q       (pins_s)
  );

  assign cnt_s[0] = pins_s.cnt0;
  assign cnt_s[1] = pins_s.cnt1;
  assign irq_s[0] = pins_s.irq0;
  assign irq_s[1] = pins_s.irq1;
  assign fast[0]  = aux_q[TMC_AUX_FAST0]; // see R19
  assign fast[1]  = aux_q[TMC_AUX_FAST1];
  assign tr[0]    = ctrl_q[TMC_CTRL_TR0];
  assign tr[1]    = ctrl_q[TMC_CTRL_TR1];

  // divide-by-twelve prescaler shared by both timers
  always_comb
  begin
    pre_d = pre_q;
    if (ce)
      pre_d = (pre_q == TMC_PRE_LAST) ? 4'h0 : pre_q + 4'h1;
  end
  assign tick12 = ce && (pre_q == TMC_PRE_LAST); // see R01

  // per timer rate, gating, pin sampling and interrupt edge detect
  for (genvar i = 0; i < 2; i++)
  begin : g_tim
    logic [3:0] nib;
    assign nib       = mode_q[TMC_NIB_W*i +: TMC_NIB_W]; // see R13
    assign rate[i]   = ce && (fast[i] || tick12); // see R01 see R02
    assign run_en[i] = tr[i] && (!nib[TMC_NIB_GATE] || irq_s[i]); // see R06 see R16
    assign inc[i]    = run_en[i] &&
                       (nib[TMC_NIB_SRC] ? (rate[i] && pend_q[i]) : rate[i]); // see R14 see R04
    assign irq_fall[i] = ce && irqp_q[i] && !irq_s[i];

    always_comb
    begin
      samp_d[i] = samp_q[i];
      pend_d[i] = pend_q[i];
      irqp_d[i] = ce ? irq_s[i] : irqp_q[i];
      if (rate[i])
      begin
        samp_d[i] = cnt_s[i];
        pend_d[i] = samp_q[i] && !cnt_s[i]; // see R03
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        samp_q[i] <= 1'b0;
        pend_q[i] <= 1'b0;
        irqp_q[i] <= 1'b1;
      end
      else
      begin
        samp_q[i] <= samp_d[i];
        pend_q[i] <= pend_d[i];
        irqp_q[i] <= irqp_d[i];
      end
    end
  end

  // apb decode; writes land at the access edge
  assign idx     = paddr[9:2];
  assign hit     = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00) &&
                   (idx >= TMC_IDX_AUX2) && (idx <= TMC_IDX_TH1);
  assign wr_en   = psel && penable && pready_q && pwrite && hit && pstrb[0];
  assign wr_ctrl = wr_en && idx == TMC_IDX_CTRL;
  assign wr_mode = wr_en && idx == TMC_IDX_MODE;
  assign wr_aux  = wr_en && idx == TMC_IDX_AUX2;
  assign wr_tl0  = wr_en && idx == TMC_IDX_TL0;
  assign wr_th0  = wr_en && idx == TMC_IDX_TH0;
  assign wr_tl1  = wr_en && idx == TMC_IDX_TL1;
  assign wr_th1  = wr_en && idx == TMC_IDX_TH1;

  assign m0 = tmc_mode_t'(mode_q[TMC_NIB_MODE +: 2]);
  assign m1 = tmc_mode_t'(mode_q[TMC_NIB_W + TMC_NIB_MODE +: 2]);

  // counting, flags and software access
  always_comb
  begin
    st0     = tmc_step(th0_q, tl0_q, m0, inc[0]);
    st1     = tmc_step(th1_q, tl1_q, m1, inc[1]); // mode 3 holds, see R09
    th0_inc = 1'b0;
    tf1_set = st1[16] && (m0 != TMC_MSPLT);
    if (m0 == TMC_MSPLT)
    begin
      st0[7:0]  = tl0_q + 8'(inc[0]); // see R10
      st0[16]   = inc[0] && (tl0_q == 8'hff);
      th0_inc   = rate[0] && tr[1]; // see R11
      st0[15:8] = th0_q + 8'(th0_inc);
      tf1_set   = th0_inc && (th0_q == 8'hff); // see R11
    end
    tf0_set = st0[16];
    ie0_set = ctrl_q[TMC_CTRL_IT0] && irq_fall[0]; // see R18
    ie1_set = ctrl_q[TMC_CTRL_IT1] && irq_fall[1];

    // a software write wins over a count in the same cycle
    tl0_d  = wr_tl0 ? pwdata[7:0] : st0[7:0]; // see R21
    th0_d  = wr_th0 ? pwdata[7:0] : st0[15:8];
    tl1_d  = wr_tl1 ? pwdata[7:0] : st1[7:0];
    th1_d  = wr_th1 ? pwdata[7:0] : st1[15:8];
    mode_d = wr_mode ? pwdata[7:0] : mode_q;
    aux_d  = wr_aux ? (pwdata[7:0] & TMC_AUX_MASK) : aux_q;

    // control: ack clears, write stores, hardware set wins over both
    ctrl_d = wr_ctrl ? pwdata[7:0] : ctrl_q;
    if (ce && ack.tim0 && !wr_ctrl)
      ctrl_d[TMC_CTRL_TF0] = 1'b0;
    if (ce && ack.tim1 && !wr_ctrl)
      ctrl_d[TMC_CTRL_TF1] = 1'b0;
    if (ce && ack.ext0 && ctrl_q[TMC_CTRL_IT0] && !wr_ctrl)
      ctrl_d[TMC_CTRL_IE0] = 1'b0; // see R17
    if (ce && ack.ext1 && ctrl_q[TMC_CTRL_IT1] && !wr_ctrl)
      ctrl_d[TMC_CTRL_IE1] = 1'b0;
    if (tf0_set)
      ctrl_d[TMC_CTRL_TF0] = 1'b1; // see R15
    if (tf1_set)
      ctrl_d[TMC_CTRL_TF1] = 1'b1; // see R15
    if (ie0_set)
      ctrl_d[TMC_CTRL_IE0] = 1'b1; // see R17
    if (ie1_set)
      ctrl_d[TMC_CTRL_IE1] = 1'b1;
    // level mode: the pin itself owns the flag
    if (ce && !ctrl_q[TMC_CTRL_IT0])
      ctrl_d[TMC_CTRL_IE0] = !irq_s[0]; // see R18 see R17
    if (ce && !ctrl_q[TMC_CTRL_IT1])
      ctrl_d[TMC_CTRL_IE1] = !irq_s[1];

    clko_d = clko_q;
    if (aux_q[TMC_AUX_CKOE0] && tf0_set)
      clko_d = !clko_q; // see R20
  end

  // apb answer: ready one cycle after setup, error on unmapped address
  always_comb
  begin
    pready_d  = psel && !penable;
    pslverr_d = psel && !penable && !hit;
    prdata_d  = prdata_q;
    if (psel && !penable)
    begin
      prdata_d = '0;
      if (hit && !pwrite)
      begin
        unique case (idx)
          TMC_IDX_AUX2: prdata_d[7:0] = aux_q;
          TMC_IDX_CTRL: prdata_d[7:0] = ctrl_q;
          TMC_IDX_MODE: prdata_d[7:0] = mode_q;
          TMC_IDX_TL0:  prdata_d[7:0] = tl0_q; // see R21
          TMC_IDX_TL1:  prdata_d[7:0] = tl1_q;
          TMC_IDX_TH0:  prdata_d[7:0] = th0_q;
          TMC_IDX_TH1:  prdata_d[7:0] = th1_q;
          default:      prdata_d[7:0] = 8'h00;
        endcase
      end
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_q     <= 4'h0;
      ctrl_q    <= TMC_CTRL_RST;
      mode_q    <= TMC_MODE_RST;
      aux_q     <= TMC_AUX_RST;
      tl0_q     <= TMC_CNT_RST;
      th0_q     <= TMC_CNT_RST;
      tl1_q     <= TMC_CNT_RST;
      th1_q     <= TMC_CNT_RST;
      clko_q    <= 1'b1;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pre_q     <= pre_d;
      ctrl_q    <= ctrl_d;
      mode_q    <= mode_d;
      aux_q     <= aux_d;
      tl0_q     <= tl0_d;
      th0_q     <= th0_d;
      tl1_q     <= tl1_d;
      th1_q     <= th1_d;
      clko_q    <= clko_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // outputs straight from flops
  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = pslverr_q;
  assign timer0_overflow_flag = ctrl_q[TMC_CTRL_TF0];
  assign timer1_overflow_flag = ctrl_q[TMC_CTRL_TF1];
  assign ext_irq0_flag        = ctrl_q[TMC_CTRL_IE0];
  assign ext_irq1_flag        = ctrl_q[TMC_CTRL_IE1];
  assign timer0_clock_out     = clko_q;
  assign timer0_clock_out_oe  = aux_q[TMC_AUX_CKOE0];

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_prescale;
    tick12 |=> !tick12 [*8];
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescale tick too early"); // see R01

  property p_fast;
    (ce && fast[0] && run_en[0] && !mode_q[TMC_NIB_SRC] && m0 == TMC_M16 &&
     !wr_tl0 && !wr_th0) |=> ({th0_q, tl0_q} == $past({th0_q, tl0_q}) + 16'h0001);
  endproperty
  a_fast: assert property (p_fast) else $error("fast select not per cycle"); // see R02

  property p_pin_count;
    (inc[0] && mode_q[TMC_NIB_SRC] && m0 == TMC_M16 && !wr_tl0 && !wr_th0)
      |=> ({th0_q, tl0_q} == $past({th0_q, tl0_q}) + 16'h0001);
  endproperty
  a_pin_count: assert property (p_pin_count) else $error("pin count not applied"); // see R04

  property p_m13_ovf;
    (inc[0] && m0 == TMC_M13 && th0_q == 8'hff && tl0_q[4:0] == 5'h1f && !wr_ctrl &&
     !wr_tl0 && !wr_th0)
      |=> timer0_overflow_flag && th0_q == 8'h00 && tl0_q[4:0] == 5'h00;
  endproperty
  a_m13_ovf: assert property (p_m13_ovf) else $error("13-bit wrap wrong"); // see R05

  property p_stop;
    (!tr[0] && !wr_tl0) |=> $stable(tl0_q);
  endproperty
  a_stop: assert property (p_stop) else $error("timer 0 counted while off"); // see R06

  property p_reload;
    (inc[0] && m0 == TMC_M8RLD && tl0_q == 8'hff && !wr_tl0 && !wr_th0)
      |=> tl0_q == $past(th0_q) && $stable(th0_q) && timer0_overflow_flag;
  endproperty
  a_reload: assert property (p_reload) else $error("reload wrong"); // see R08

  property p_t1_hold;
    (m1 == TMC_MSPLT && !wr_tl1 && !wr_th1) |=> $stable({th1_q, tl1_q});
  endproperty
  a_t1_hold: assert property (p_t1_hold) else $error("timer 1 moved in mode 3"); // see R09

  property p_split_hi;
    (m0 == TMC_MSPLT && !tr[1] && !wr_th0) |=> $stable(th0_q);
  endproperty
  a_split_hi: assert property (p_split_hi) else $error("high byte ran without run"); // see R11

  property p_set_wins;
    (tf0_set && ack.tim0) |=> timer0_overflow_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("overflow lost"); // see R15

  property p_level;
    (ce && !ctrl_q[TMC_CTRL_IT0]) |=> ext_irq0_flag == !$past(irq_s[0]);
  endproperty
  a_level: assert property (p_level) else $error("level flag wrong"); // see R17

  c_reload: cover property (inc[0] && m0 == TMC_M8RLD && tl0_q == 8'hff);
  c_split:  cover property (m0 == TMC_MSPLT && tf1_set);
  c_edge:   cover property (ie0_set);
  c_write:  cover property (wr_tl1);

endmodule // tmc_timers
